// ===== hw/dodt_ctrl.sv
// memory controller end: APB registers, link clock and pin drive
// assumes pclk at 125 MHz; link clock is pclk divided by two
`timescale 1ns/1ps
`include "dodt_cfg.svh"
module dodt_ctrl (
    input wire logic pclk, // register clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    dodt_link_if.ctl link // link to the device
);
    import dodt_pkg::*;

    logic run;
    logic tie;
    logic level;
    logic pend;
    dodt_cmd_type pend_kind;
    logic [1:0] pend_sel;
    logic [12:0] pend_addr;
    logic [12:0] sh_mr0;
    logic [12:0] sh_mr1;
    logic [12:0] sh_mr2;
    logic err_dll;
    logic err_nom;
    logic ck_q;
    logic [2:0] hold;
    logic [2:0] next_hold;
    logic next_odt;
    logic [11:0] s1;
    logic [11:0] s2;
    logic wr_acc;
    logic cmd_hit;
    logic bad_dll;
    logic bad_nom;
    logic refuse;
    logic bl8;

    assign pready = 1'b1;
    assign wr_acc = psel && penable && pwrite;
    assign cmd_hit = wr_acc && paddr == `DODT_OFS_CMD;
    // an MR2 load enabling write termination while the MR1 shadow has the DLL off is refused
    assign bad_dll = pwdata[3:2] == 2'h2 && sh_mr1[`DODT_MR1_DLL_OFF] &&
                     |pwdata[16 + `DODT_MR2_WR_LO +: 2];
    // nominal used in writes must be RZQ/2, 4 or 6
    assign bad_nom = pwdata[3:2] == 2'h1 &&
                     ~|sh_mr2[`DODT_MR2_WR_HI:`DODT_MR2_WR_LO] &&
                     pwdata[16 + `DODT_MR1_NOM_B2];
    assign refuse = pwdata[1:0] == 2'h1 && (bad_dll || bad_nom);

    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            if (cmd_hit) begin
                pslverr = pend || refuse;
            end else if (paddr != `DODT_OFS_CTRL && paddr != `DODT_OFS_STAT) begin
                pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 1'b0;
            tie <= 1'b0;
            level <= 1'b0;
        end else if (wr_acc && paddr == `DODT_OFS_CTRL) begin
            run <= pwdata[0];
            tie <= pwdata[1];
            level <= pwdata[2];
        end
    end

    // command slot; a whole MR1 word goes out in one load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend <= 1'b0;
            pend_kind <= DODT_CMD_NOP;
            pend_sel <= 2'h0;
            pend_addr <= 13'h0000;
        end else if (cmd_hit && !pend && !refuse) begin
            pend <= 1'b1;
            pend_kind <= dodt_cmd_type'(pwdata[1:0]);
            pend_sel <= pwdata[3:2];
            pend_addr <= pwdata[28:16];
        end else if (ck_q) begin
            pend <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_mr0 <= 13'h0000;
            sh_mr1 <= 13'h0000;
            sh_mr2 <= 13'h0000;
        end else if (cmd_hit && !pend && !refuse && pwdata[1:0] == 2'h1) begin
            case (pwdata[3:2])
                2'h0: sh_mr0 <= pwdata[28:16];
                2'h1: sh_mr1 <= pwdata[28:16];
                2'h2: sh_mr2 <= pwdata[28:16];
                default: ;
            endcase
        end
    end

    // sticky errors: set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_dll <= 1'b0;
            err_nom <= 1'b0;
        end else begin
            if (cmd_hit && pwdata[1:0] == 2'h1 && bad_dll) begin
                err_dll <= 1'b1;
            end else if (wr_acc && paddr == `DODT_OFS_STAT && pwdata[1]) begin
                err_dll <= 1'b0;
            end
            if (cmd_hit && pwdata[1:0] == 2'h1 && bad_nom) begin
                err_nom <= 1'b1;
            end else if (wr_acc && paddr == `DODT_OFS_STAT && pwdata[2]) begin
                err_nom <= 1'b0;
            end
        end
    end

    // link clock divider; odt, cmd, msel and addr change as ck falls, rst_n follows run on every rising pclk edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ck_q <= 1'b0;
        end else begin
            ck_q <= run ? !ck_q : 1'b0;
        end
    end
    assign link.ck = ck_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.rst_n <= 1'b0;
        end else begin
            link.rst_n <= run;
        end
    end

    assign bl8 = sh_mr0[`DODT_MR0_BL_LO +: 2] == 2'h0 ||
                 (sh_mr0[`DODT_MR0_BL_LO +: 2] == 2'h1 &&
                  pend_addr[`DODT_OTF_BL8_BIT]);

    // pin hold: remaining link clocks the pin must stay high
    always_comb begin
        next_hold = (hold != 3'h0) ? hold - 3'h1 : 3'h0;
        next_odt = level || tie || (hold != 3'h0);
        if (next_odt && !link.odt) begin
            next_hold = `DODT_ODTH4 - 3'h1;
        end
        if (next_odt && pend && pend_kind == DODT_CMD_WRITE) begin
            if (bl8 && next_hold < `DODT_ODTH8 - 3'h1) begin
                next_hold = `DODT_ODTH8 - 3'h1;
            end else if (next_hold < `DODT_ODTH4 - 3'h1) begin
                next_hold = `DODT_ODTH4 - 3'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold <= 3'h0;
            link.odt <= 1'b0;
            link.cmd <= DODT_CMD_NOP;
            link.msel <= 2'h0;
            link.addr <= 13'h0000;
        end else if (ck_q) begin
            hold <= next_hold;
            link.odt <= next_odt;
            link.cmd <= pend ? pend_kind : DODT_CMD_NOP;
            link.msel <= pend_sel;
            link.addr <= pend_addr;
        end
    end

    // device status into the register domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= 12'h000;
            s2 <= 12'h000;
        end else begin
            s1 <= {link.illegal, link.unsure, link.settle,
                   link.rtt_dqs, link.rtt_dq, 3'h0};
            s2 <= s1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `DODT_OFS_CTRL: prdata <= {29'h0, level, tie, run};
                `DODT_OFS_STAT: prdata <= {20'h0, s2[11:3], err_nom, err_dll, pend};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

endmodule : dodt_ctrl

// ===== hw/dodt_cfg.svh
// constants for the dynamic termination link and its controller
// assumes inclusion by bare name from the controller and device files
// Functional notes
// - either MR2 write bit set enables dynamic termination
// - controller refuses MR2 write termination loads with DLL off
// - MR1 bits 9,6,2 select nominal value
// - MR2 bits 10,9 select write value
// - nominal used in writes: only RZQ/2,4,6
// - idle: nominal value, gated by delayed pin
// - every write variant triggers dynamic switching
// - switch to write value at WL-2
// - back to nominal at latency plus 4/6
// - value undefined during transition window
// - pin and latencies govern on/off timing
// - pin high four clocks, also after chop
// - pin high six clocks after BL8 write
// - tied-high pin tolerated, single rank
// - nominal toggled in same MR1 as leveling
// - MR1 change settles after latency+tMOD+1
// - leveling: strobes nominal, data unterminated
// - latency equals CWL plus AL minus 2
`ifndef DODT_CFG_SVH
`define DODT_CFG_SVH
`define DODT_MR1_DLL_OFF 0
`define DODT_MR1_NOM_B0 2
`define DODT_MR1_AL_LO 3
`define DODT_MR1_NOM_B1 6
`define DODT_MR1_WLVL 7
`define DODT_MR1_NOM_B2 9
`define DODT_MR2_CWL_LO 3
`define DODT_MR2_WR_LO 9
`define DODT_MR2_WR_HI 10
`define DODT_MR0_CL_LO 4
`define DODT_MR0_BL_LO 0
`define DODT_OTF_BL8_BIT 12
`define DODT_CWL_BASE 5'h05
`define DODT_CL_BASE 5'h04
`define DODT_ODTL_SUB 5'h02
`define DODT_ODTH4 3'h4
`define DODT_ODTH8 3'h6
`define DODT_TMOD_CK 6'h0C
`define DODT_EXTRA_CK 6'h01
`define DODT_OFS_CTRL 12'h000
`define DODT_OFS_CMD 12'h004
`define DODT_OFS_STAT 12'h008
`endif

// ===== hw/dodt_pkg.sv
// types shared by both ends of the termination link
// assumes dodt_cfg.svh holds the numeric constants
package dodt_pkg;
    typedef enum logic [1:0] {DODT_CMD_NOP, DODT_CMD_MRS, DODT_CMD_WRITE} dodt_cmd_type;
    typedef enum logic [2:0] {
        DODT_RTT_OFF, DODT_RTT_RZQ2, DODT_RTT_RZQ4, DODT_RTT_RZQ6,
        DODT_RTT_RZQ8, DODT_RTT_RZQ12
    } dodt_rtt_type;
endpackage : dodt_pkg

// ===== hw/dodt_link_if.sv
// link between the memory controller and the termination logic
// assumes the controller makes ck and all inputs of the device
`timescale 1ns/1ps
interface dodt_link_if;
    import dodt_pkg::*;
    logic ck;
    logic rst_n;
    logic odt;
    dodt_cmd_type cmd;
    logic [1:0] msel;
    logic [12:0] addr;
    dodt_rtt_type rtt_dq;
    dodt_rtt_type rtt_dqs;
    logic settle;
    logic unsure;
    logic illegal;
    modport dev (input ck, rst_n, odt, cmd, msel, addr,
                 output rtt_dq, rtt_dqs, settle, unsure, illegal);
    modport ctl (output ck, rst_n, odt, cmd, msel, addr,
                 input rtt_dq, rtt_dqs, settle, unsure, illegal);
endinterface : dodt_link_if

// ===== hw/dodt_device.sv
// termination control inside the memory device
// assumes ck, rst_n and all commands come from the controller
`timescale 1ns/1ps
`include "dodt_cfg.svh"
module dodt_device (
    dodt_link_if.dev link, // link to the controller
    output logic dyn_en, // dynamic termination enabled
    output logic [4:0] odt_lat // current on/off latency
);
    import dodt_pkg::*;

    localparam int PIPE = 32;

    logic [12:0] mr0;
    logic [12:0] mr1;
    logic [12:0] mr2;
    logic [PIPE-1:0] odt_pipe;
    logic [5:0] wr_cnt;
    logic wr_busy;
    logic wr_bc4;
    logic [5:0] unsure_cnt;
    logic [2:0] nom_code;
    logic [1:0] wr_code;
    logic nom_bad;
    logic wr_bad;
    logic dyn_act;
    logic [4:0] cwl;
    logic [4:0] cl;
    logic [4:0] al;
    logic odt_on;
    logic in_wr;
    logic is_bc4;
    logic [5:0] wr_len;
    dodt_rtt_type nom_val;
    dodt_rtt_type wr_val;
    dodt_rtt_type next_dq;
    dodt_rtt_type next_dqs;

    // mode register loads
    always_ff @(posedge link.ck or negedge link.rst_n) begin
        if (!link.rst_n) begin
            mr0 <= 13'h0000;
            mr1 <= 13'h0000;
            mr2 <= 13'h0000;
        end else if (link.cmd == DODT_CMD_MRS) begin
            case (link.msel)
                2'h0: mr0 <= link.addr;
                2'h1: mr1 <= link.addr;
                2'h2: mr2 <= link.addr;
                default: ;
            endcase
        end
    end

    assign nom_code = {mr1[`DODT_MR1_NOM_B2], mr1[`DODT_MR1_NOM_B1],
                       mr1[`DODT_MR1_NOM_B0]};
    assign wr_code = mr2[`DODT_MR2_WR_HI:`DODT_MR2_WR_LO];
    assign dyn_en = |wr_code;
    // dynamic switching is not done with the DLL off
    assign dyn_act = dyn_en && !mr1[`DODT_MR1_DLL_OFF];
    assign nom_bad = nom_code[2] && nom_code[1];
    assign wr_bad = &wr_code;

    always_comb begin
        case (nom_code)
            3'h1: nom_val = DODT_RTT_RZQ4;
            3'h2: nom_val = DODT_RTT_RZQ2;
            3'h3: nom_val = DODT_RTT_RZQ6;
            3'h4: nom_val = DODT_RTT_RZQ12;
            3'h5: nom_val = DODT_RTT_RZQ8;
            default: nom_val = DODT_RTT_OFF;
        endcase
    end

    always_comb begin
        case (wr_code)
            2'h1: wr_val = DODT_RTT_RZQ4;
            2'h2: wr_val = DODT_RTT_RZQ2;
            default: wr_val = DODT_RTT_OFF;
        endcase
    end

    // latency from write and additive latency
    assign cwl = `DODT_CWL_BASE + {2'h0, mr2[`DODT_MR2_CWL_LO +: 3]};
    assign cl = `DODT_CL_BASE + {2'h0, mr0[`DODT_MR0_CL_LO +: 3]};
    always_comb begin
        case (mr1[`DODT_MR1_AL_LO +: 2])
            2'h1: al = cl - 5'h01;
            2'h2: al = cl - 5'h02;
            default: al = 5'h00;
        endcase
    end
    assign odt_lat = cwl + al - `DODT_ODTL_SUB;

    // pin history; bit k is the pin sampled k edges ago
    always_ff @(posedge link.ck or negedge link.rst_n) begin
        if (!link.rst_n) begin
            odt_pipe <= '0;
        end else begin
            odt_pipe <= {odt_pipe[PIPE-2:0], link.odt};
        end
    end
    // on/off follows the pin after the latency
    assign odt_on = odt_pipe[odt_lat];

    // burst length of the write being registered
    always_comb begin
        case (mr0[`DODT_MR0_BL_LO +: 2])
            2'h1: is_bc4 = !link.addr[`DODT_OTF_BL8_BIT];
            2'h2: is_bc4 = 1'b1;
            default: is_bc4 = 1'b0;
        endcase
    end

    // write window tracker, restarted by every write variant
    always_ff @(posedge link.ck or negedge link.rst_n) begin
        if (!link.rst_n) begin
            wr_cnt <= 6'h00;
            wr_busy <= 1'b0;
            wr_bc4 <= 1'b0;
        end else if (link.cmd == DODT_CMD_WRITE && dyn_act) begin
            wr_cnt <= 6'h01;
            wr_busy <= 1'b1;
            wr_bc4 <= is_bc4;
        end else if (wr_busy) begin
            wr_cnt <= wr_cnt + 6'h01;
            if (wr_cnt == wr_len) begin
                wr_busy <= 1'b0;
            end
        end
    end

    assign wr_len = {1'b0, odt_lat} +
                    (wr_bc4 ? {3'h0, `DODT_ODTH4} : {3'h0, `DODT_ODTH8});
    // write value from WL-2 until latency plus burst
    assign in_wr = wr_busy && (wr_cnt > {1'b0, odt_lat}) &&
                   (wr_cnt <= wr_len);

    // value for data lines and strobes
    always_comb begin
        next_dq = DODT_RTT_OFF;
        next_dqs = DODT_RTT_OFF;
        if (nom_bad || wr_bad) begin
            next_dq = DODT_RTT_OFF;
            next_dqs = DODT_RTT_OFF;
        end else if (mr1[`DODT_MR1_WLVL]) begin
            // leveling: strobes carry nominal, data lines none
            next_dqs = odt_on ? nom_val : DODT_RTT_OFF;
            next_dq = DODT_RTT_OFF;
        end else if (odt_on) begin
            // a tied-high pin simply keeps this branch live
            if (in_wr) begin
                next_dq = wr_val;
            end else begin
                next_dq = nom_val;
            end
            next_dqs = next_dq;
        end
    end

    always_ff @(posedge link.ck or negedge link.rst_n) begin
        if (!link.rst_n) begin
            link.rtt_dq <= DODT_RTT_OFF;
            link.rtt_dqs <= DODT_RTT_OFF;
        end else begin
            link.rtt_dq <= next_dq;
            link.rtt_dqs <= next_dqs;
        end
    end

    // one clock marks the half-clock skew window of a change
    always_ff @(posedge link.ck or negedge link.rst_n) begin
        if (!link.rst_n) begin
            link.settle <= 1'b0;
        end else begin
            link.settle <= (next_dq != link.rtt_dq) ||
                           (next_dqs != link.rtt_dqs);
        end
    end

    // uncertainty after a nominal change by MR1 load
    always_ff @(posedge link.ck or negedge link.rst_n) begin
        if (!link.rst_n) begin
            unsure_cnt <= 6'h00;
        end else if (link.cmd == DODT_CMD_MRS && link.msel == 2'h1 &&
                     {link.addr[`DODT_MR1_NOM_B2], link.addr[`DODT_MR1_NOM_B1],
                      link.addr[`DODT_MR1_NOM_B0]} != nom_code) begin
            unsure_cnt <= {1'b0, odt_lat} + `DODT_TMOD_CK + `DODT_EXTRA_CK;
        end else if (unsure_cnt != 6'h00) begin
            unsure_cnt <= unsure_cnt - 6'h01;
        end
    end

    always_ff @(posedge link.ck or negedge link.rst_n) begin
        if (!link.rst_n) begin
            link.unsure <= 1'b0;
            link.illegal <= 1'b0;
        end else begin
            link.unsure <= (unsure_cnt > 6'h01) ||
                           (link.cmd == DODT_CMD_MRS && link.msel == 2'h1);
            link.illegal <= nom_bad || wr_bad;
        end
    end

endmodule : dodt_device

// ===== sim/dodt_link_asserts.sv
// assertions on the termination link between controller and device
// assumes its inputs are the link signals, sampled on the link clock
`timescale 1ns/1ps
module dodt_link_asserts (
    input logic ck, // link clock
    input logic rst_n, // device reset, active low
    input logic odt, // termination pin
    input dodt_pkg::dodt_cmd_type cmd, // command
    input logic [1:0] msel, // mode register select
    input logic [12:0] addr, // mode word or burst select
    input dodt_pkg::dodt_rtt_type rtt_dq, // data termination
    input dodt_pkg::dodt_rtt_type rtt_dqs, // strobe termination
    input logic settle, // change pulse
    input logic unsure, // nominal value uncertain
    input logic illegal // reserved code present
);
    import dodt_pkg::*;
    logic [12:0] mr0;
    logic [12:0] mr1;
    logic [12:0] mr2;
    logic [6:0] uns_n;
    logic mrs;
    logic bl8;
    logic wr_hi;
    logic nom_chg;
    assign mrs = cmd == DODT_CMD_MRS;
    assign bl8 = mr0[1:0] == 2'h0 || (mr0[1:0] == 2'h1 && addr[12]);
    assign wr_hi = cmd == DODT_CMD_WRITE && odt;
    assign nom_chg = mrs && msel == 2'h1 && {addr[9], addr[6], addr[2]} != {mr1[9], mr1[6], mr1[2]};
    // shadow of the mode words the device was given
    always_ff @(posedge ck or negedge rst_n) begin
        if (!rst_n) begin
            mr0 <= 13'h0000;
            mr1 <= 13'h0000;
            mr2 <= 13'h0000;
        end else if (mrs && msel == 2'h0) begin
            mr0 <= addr;
        end else if (mrs && msel == 2'h1) begin
            mr1 <= addr;
        end else if (mrs && msel == 2'h2) begin
            mr2 <= addr;
        end
    end
    // length of the current uncertainty stretch
    always_ff @(posedge ck or negedge rst_n) begin
        if (!rst_n) begin
            uns_n <= 7'h00;
        end else begin
            uns_n <= unsure ? uns_n + 7'h01 : 7'h00;
        end
    end
    default clocking dcb @(posedge ck);
    endclocking
    default disable iff (!rst_n);
    AST_ODT_HOLD_ON: assert property ($rose(odt) |-> odt[*4])
        else $error("pin fell within four clocks of rising");
    AST_ODT_HOLD_BC4: assert property (wr_hi && !bl8 |-> odt[*4])
        else $error("pin fell within four clocks of a chopped write");
    AST_ODT_HOLD_BL8: assert property (wr_hi && bl8 |-> odt[*6])
        else $error("pin fell within six clocks of a full write");
    AST_DLL_WR_OFF: assert property (mrs && msel == 2'h2 && addr[10:9] != 2'h0 |-> !mr1[0])
        else $error("write termination enabled with dll off");
    AST_NOM_WR_LIMIT: assert property (mrs && msel == 2'h1 && addr[9] |-> mr2[10:9] != 2'h0)
        else $error("strong nominal value loaded without write value");
    AST_RSV_OFF: assert property (illegal[*2] |-> rtt_dq == DODT_RTT_OFF && rtt_dqs == DODT_RTT_OFF)
        else $error("termination on with reserved code");
    AST_ILL_CAUSE: assert property ($rose(illegal) |-> $past(cmd, 1) == DODT_CMD_MRS || $past(cmd, 2) == DODT_CMD_MRS)
        else $error("illegal flag rose without a mode load");
    AST_SETTLE: assert property ($changed(rtt_dq) || $changed(rtt_dqs) |-> ##[0:1] settle)
        else $error("no settle pulse after a value change");
    AST_UNSURE_RISE: assert property (nom_chg |-> ##[1:2] unsure)
        else $error("no uncertainty after nominal change");
    AST_UNSURE_END: assert property (uns_n < 7'h28)
        else $error("uncertainty lasts too long");
endmodule : dodt_link_asserts

// ===== sim/tb.sv
// self-checking bench: controller and device joined by the link interface
// assumes the design files and the link checker are compiled first
`timescale 1ns/1ps
module tb;
    import dodt_pkg::*;
    typedef struct {logic [2:0] nom; logic [1:0] wr; dodt_rtt_type rtt; logic ill;} dodt_row_type;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic dyn_en;
    logic [4:0] odt_lat;
    logic [31:0] rd;
    logic er;
    logic cer;
    time t_wr;
    time t_on;
    int c;
    int fails = 0;
    int n_tests = 0;
    dodt_row_type rows [11];
    logic [1:0] wmode [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h0};
    logic [1:0] wsel [5] = '{2'h1, 2'h1, 2'h2, 2'h1, 2'h0};
    logic wa12 [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    dodt_rtt_type wexp [5] = '{DODT_RTT_RZQ4, DODT_RTT_RZQ4, DODT_RTT_RZQ2,
        DODT_RTT_RZQ4, DODT_RTT_RZQ4};
    int wlen [5] = '{6, 6, 4, 4, 0};
    dodt_link_if link_if ();
    dodt_ctrl dodt_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link_if));
    dodt_device dodt_device_inst (.link(link_if), .dyn_en(dyn_en), .odt_lat(odt_lat));
    dodt_link_asserts dodt_link_asserts_inst (.ck(link_if.ck), .rst_n(link_if.rst_n),
        .odt(link_if.odt), .cmd(link_if.cmd), .msel(link_if.msel), .addr(link_if.addr),
        .rtt_dq(link_if.rtt_dq), .rtt_dqs(link_if.rtt_dqs), .settle(link_if.settle),
        .unsure(link_if.unsure), .illegal(link_if.illegal));
    always #4 pclk = ~pclk;
    always @(posedge link_if.ck) begin
        if (link_if.cmd === DODT_CMD_WRITE) begin
            t_wr = $time;
        end
    end
    function automatic logic [12:0] mr1w(input logic [2:0] k);
        return {3'h0, k[2], 2'h0, k[1], 3'h0, k[0], 2'h0};
    endfunction : mr1w
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task print_verdict;
        if (fails == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    // one transfer, entered just after a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // pready is tied high, so this wait for ready never loops
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // issue a link command and wait until it has left
    task cmd(input logic [1:0] k, input logic [1:0] s, input logic [12:0] w);
        apb(1'b1, 12'h004, {3'h0, w, 12'h000, s, k});
        cer = er;
        rd = 32'h1;
        while (rd[0] !== 1'b0) begin
            apb(1'b0, 12'h008, 32'h0);
        end
    endtask : cmd
    // count link cycles that carry the write value
    task win(input dodt_rtt_type e);
        c = 0;
        repeat (40) begin
            @(posedge link_if.ck);
            if (link_if.rtt_dq === e) begin
                if (c == 0) begin
                    t_on = $time;
                end
                c++;
            end
        end
        @(posedge pclk);
    endtask : win
    initial begin
        #300000;
        fails++;
        print_verdict();
    end
    initial begin
        rows = '{'{3'h0, 2'h1, DODT_RTT_OFF, 1'b0}, '{3'h1, 2'h1, DODT_RTT_RZQ4, 1'b0},
            '{3'h2, 2'h1, DODT_RTT_RZQ2, 1'b0}, '{3'h3, 2'h1, DODT_RTT_RZQ6, 1'b0},
            '{3'h4, 2'h1, DODT_RTT_RZQ12, 1'b0}, '{3'h5, 2'h1, DODT_RTT_RZQ8, 1'b0},
            '{3'h6, 2'h1, DODT_RTT_OFF, 1'b1}, '{3'h7, 2'h1, DODT_RTT_OFF, 1'b1},
            '{3'h1, 2'h3, DODT_RTT_OFF, 1'b1}, '{3'h1, 2'h0, DODT_RTT_RZQ4, 1'b0},
            '{3'h1, 2'h2, DODT_RTT_RZQ4, 1'b0}};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, 12'h000, 32'h5);
        foreach (rows[i]) begin
            cmd(2'h1, 2'h2, {2'h0, rows[i].wr, 9'h000});
            cmd(2'h1, 2'h1, mr1w(rows[i].nom));
            repeat (120) @(posedge pclk);
            apb(1'b0, 12'h008, 32'h0);
            check(32'(rd[5:3]), 32'(rows[i].rtt));
            check(32'(rd[8:6]), 32'(rows[i].rtt));
            check(32'(rd[11]), 32'(rows[i].ill));
            check(32'(dyn_en), 32'(rows[i].wr != 2'h0));
        end
        // refused loads, error flags, unmapped space
        cmd(2'h1, 2'h2, 13'h0000);
        cmd(2'h1, 2'h1, 13'h0200);
        check(32'(cer), 32'h1);
        apb(1'b1, 12'h008, 32'h6);
        cmd(2'h1, 2'h1, 13'h0001);
        cmd(2'h1, 2'h2, 13'h0200);
        check(32'(cer), 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        check(32'(rd[2:1]), 32'h1);
        apb(1'b1, 12'h008, 32'h6);
        apb(1'b0, 12'h008, 32'h0);
        check(32'(rd[2:1]), 32'h0);
        apb(1'b0, 12'h00C, 32'h0);
        check(32'(er), 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h0);
        // write windows for every burst mode, latency five
        cmd(2'h1, 2'h1, mr1w(3'h3));
        repeat (120) @(posedge pclk);
        for (int i = 0; i < 5; i++) begin
            cmd(2'h1, 2'h0, {11'h000, wmode[i]});
            cmd(2'h1, 2'h2, {2'h0, wsel[i], 9'h010});
            cmd(2'h2, 2'h0, {wa12[i], 12'h000});
            win(wexp[i]);
            check(32'(c), wlen[i]);
            if (c > 0) begin
                check(32'((t_on - t_wr) / 16), 32'h7);
            end
        end
        check(32'(odt_lat), 32'h5);
        // leveling on, then leveling and nominal off
        cmd(2'h1, 2'h1, mr1w(3'h1) | 13'h0080);
        // nominal code changed: uncertainty must show, then end
        repeat (4) @(posedge pclk);
        apb(1'b0, 12'h008, 32'h0);
        check(32'(rd[10]), 32'h1);
        repeat (120) @(posedge pclk);
        apb(1'b0, 12'h008, 32'h0);
        check(32'(rd[8:3]), 32'h10);
        check(32'(rd[10]), 32'h0);
        cmd(2'h1, 2'h1, 13'h0000);
        repeat (120) @(posedge pclk);
        apb(1'b0, 12'h008, 32'h0);
        check(32'(rd[8:3]), 32'h0);
        // pin tied high, nominal off, write value on
        apb(1'b1, 12'h000, 32'h3);
        cmd(2'h1, 2'h2, 13'h0210);
        repeat (40) @(posedge pclk);
        check(32'({link_if.odt, link_if.rtt_dq}), 32'h8);
        cmd(2'h2, 2'h0, 13'h1000);
        win(DODT_RTT_RZQ4);
        check(32'(c), 32'h6);
        // short level pulse: pin must stay high four link clocks
        apb(1'b1, 12'h000, 32'h1);
        repeat (8) @(posedge pclk);
        apb(1'b1, 12'h000, 32'h5);
        apb(1'b1, 12'h000, 32'h1);
        repeat (2) @(posedge pclk);
        check(32'(link_if.odt), 32'h1);
        repeat (8) @(posedge pclk);
        check(32'(link_if.odt), 32'h0);
        // reset in mid-run
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        check(32'({link_if.rst_n, link_if.odt, link_if.ck, link_if.rtt_dq}), 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h008, 32'h0);
        check(rd, 32'h0);
        print_verdict();
    end
endmodule : tb
